// >>> core/periodic_timer_compare_pwm.sv
// periodic_timer_compare_pwm: 10-bit periodic timer with compare output,
// plain timer and edge-aligned pwm modes, behind a wishbone slave.
// assumes single clock; timer clock is an enable from a prescaler.
`timescale 1ns/10ps

// Summary of operation
// - compare a held as 10 bits, split bytes
// - period compare held as 10 bits, split bytes
// - high bytes read zero above bit one
// - mode field 00 is compare match output
// - clear select low: clear on period, both flags
// - clear select high: clear on a, a flag only
// - compare a zero: overflow at 3ff, no flag
// - compare mode: pin moves only on a match
// - output function sets high, low, toggle, none
// - enable rising loads initial pin level
// - mode 11 is compare mode without pin
// - pwm: period clears counter, a sets duty
// - period zero gives 1024 clocks
// - duty not below a nonzero period gives full duty
// - pwm raises both flags on matches
// - pwm output control, force, polarity invert
// - pwm counting continues while forced
// - compare function codes 00,01,10,11
// - pwm function codes 00,01,10,11
// - enable rising clears counter, falling holds
// - pause holds count, resumes from it
module periodic_timer_compare_pwm
    import ptm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic pin_o,
    output logic pin_oe_n_o
);
    typedef struct packed {
        logic [7:0] ctrl_zero;
        logic [7:0] ctrl_one;
        logic [9:0] cmpa;
        logic [9:0] per;
        logic [7:0] prescale;
        logic [9:0] count;
        logic flag_a;
        logic flag_p;
        logic enable_d;
        logic level;
        logic pin;
        logic pin_oe_n;
        logic [31:0] rdata;
    } tmr_s;
    tmr_s st;
    tmr_s next_st;

    logic tick;
    logic wr;
    logic rd;

    // ------------------------------------------------------------
    // bus slave and prescaler
    // ------------------------------------------------------------
    wb_byte_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .sel_i(sel_i[0]),
        .wr_o(wr),
        .rd_o(rd),
        .ack_o(ack_o)
    );

    tick_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .divisor_i(st.prescale),
        .tick_o(tick)
    );

    function automatic logic [7:0] read_mux(input logic [7:0] a,
                                            input tmr_s s);
        case (a)
            CTRL_ZERO_ADDR: read_mux = s.ctrl_zero & 8'hf8;
            CTRL_ONE_ADDR: read_mux = s.ctrl_one;
            COUNT_LOW_ADDR: read_mux = s.count[7:0];
            COUNT_HIGH_ADDR: read_mux = {6'h00, s.count[9:8]};
            CMPA_LOW_ADDR: read_mux = s.cmpa[7:0];
            CMPA_HIGH_ADDR: read_mux = {6'h00, s.cmpa[9:8]};
            PER_LOW_ADDR: read_mux = s.per[7:0];
            PER_HIGH_ADDR: read_mux = {6'h00, s.per[9:8]};
            FLAGS_ADDR: read_mux = {6'h00, s.flag_p, s.flag_a};
            PRESCALE_ADDR: read_mux = s.prescale;
            default: read_mux = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // timer core
    // ------------------------------------------------------------
    logic [1:0] mode;
    logic [1:0] func;
    logic enable;
    logic paused;
    logic enable_rise;
    logic running;
    logic match_a;
    logic match_p;
    logic at_max;
    logic [9:0] per_last;
    logic match_last;
    logic set_a;
    logic set_p;
    logic clear_cnt;
    logic pwm_level;
    logic pwm_pin;
    logic [7:0] wbyte;

    assign mode = {st.ctrl_one[MODE_HI_BIT], st.ctrl_one[MODE_LO_BIT]};
    assign func = {st.ctrl_one[FUNC_HI_BIT], st.ctrl_one[FUNC_LO_BIT]};
    assign enable = st.ctrl_zero[ENABLE_BIT];
    assign paused = st.ctrl_zero[PAUSE_BIT];
    assign enable_rise = enable & ~st.enable_d;
    assign running = enable & ~paused & tick & ~enable_rise;
    assign match_a = st.count == st.cmpa;
    assign match_p = st.count == st.per;
    assign at_max = st.count == COUNT_MAX;
    assign per_last = st.per - 10'h001;
    assign match_last = st.count == per_last;
    assign wbyte = dat_i[7:0];

    always_comb begin
        set_a = 1'b0;
        set_p = 1'b0;
        clear_cnt = 1'b0;
        if (running) begin
            if (mode == MODE_PWM) begin
                // clear select ignored here
                set_a = match_a;
                set_p = match_last;
                // counts 0 to period-1; period zero ends at 3ff
                clear_cnt = match_last;
            end else if (mode == MODE_COMPARE || mode == MODE_TIMER) begin
                if (st.ctrl_one[CLRSEL_BIT]) begin
                    // compare a zero never flags, wraps at max
                    set_a = match_a & (st.cmpa != 10'h000);
                    clear_cnt = set_a | at_max;
                end else begin
                    set_a = match_a & (st.cmpa != 10'h000);
                    set_p = match_p & (st.per != 10'h000);
                    clear_cnt = set_p | at_max;
                end
            end
        end
    end

    // pwm active while count below duty; duty >= nonzero period is full
    always_comb begin
        if (st.cmpa >= st.per && st.per != 10'h000) begin
            pwm_level = 1'b1;
        end else begin
            pwm_level = st.count < st.cmpa;
        end
        case (func)
            FUNC_INACTIVE: pwm_pin = ~st.ctrl_one[OCTRL_BIT];
            FUNC_ACTIVE: pwm_pin = st.ctrl_one[OCTRL_BIT];
            FUNC_WAVE: pwm_pin = pwm_level ~^ st.ctrl_one[OCTRL_BIT];
            default: pwm_pin = ~st.ctrl_one[OCTRL_BIT];
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.enable_d = enable;
        if (enable_rise) begin
            next_st.count = 10'h000;
            next_st.level = st.ctrl_one[OCTRL_BIT];
        end else if (running) begin
            next_st.count = clear_cnt ? 10'h000 : st.count + 10'h001;
        end
        // compare output moves only on an a flag
        if (set_a && mode == MODE_COMPARE && !enable_rise) begin
            case (func)
                FUNC_LOW: next_st.level = 1'b0;
                FUNC_HIGH: next_st.level = 1'b1;
                FUNC_TOGGLE: next_st.level = ~st.level;
                default: next_st.level = st.level;
            endcase
        end
        // flags: set wins over a software clear
        if (wr && adr_i == FLAGS_ADDR) begin
            if (wbyte[FLAG_A_BIT]) next_st.flag_a = 1'b0;
            if (wbyte[FLAG_P_BIT]) next_st.flag_p = 1'b0;
        end
        if (set_a) next_st.flag_a = 1'b1;
        if (set_p) next_st.flag_p = 1'b1;
        // output pin with polarity; released in timer mode
        case (mode)
            MODE_COMPARE: begin
                next_st.pin = next_st.level ^ st.ctrl_one[POL_BIT];
                next_st.pin_oe_n = 1'b0;
            end
            MODE_PWM: begin
                next_st.pin = pwm_pin ^ st.ctrl_one[POL_BIT];
                next_st.pin_oe_n = 1'b0;
            end
            default: begin
                next_st.pin = 1'b0;
                next_st.pin_oe_n = 1'b1;
            end
        endcase
        // register writes
        if (wr) begin
            case (adr_i)
                CTRL_ZERO_ADDR: next_st.ctrl_zero = wbyte & 8'hf8;
                CTRL_ONE_ADDR: next_st.ctrl_one = wbyte;
                CMPA_LOW_ADDR: next_st.cmpa[7:0] = wbyte;
                CMPA_HIGH_ADDR: next_st.cmpa[9:8] = wbyte[1:0];
                PER_LOW_ADDR: next_st.per[7:0] = wbyte;
                PER_HIGH_ADDR: next_st.per[9:8] = wbyte[1:0];
                PRESCALE_ADDR: next_st.prescale = wbyte;
                default: next_st.prescale = next_st.prescale;
            endcase
        end
        if (rd) begin
            next_st.rdata = {24'h000000, read_mux(adr_i, st)};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.ctrl_zero <= CTRL_ZERO_RESET;
            st.ctrl_one <= CTRL_ONE_RESET;
            st.cmpa <= CMP_RESET;
            st.per <= CMP_RESET;
            st.prescale <= PRESCALE_RESET;
            st.pin_oe_n <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign dat_o = st.rdata;
    assign pin_o = st.pin;
    assign pin_oe_n_o = st.pin_oe_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_cmpa_high_zero: assert property (@(posedge clk_i)
        disable iff (rst_i) ack_o && $past(adr_i) == CMPA_HIGH_ADDR
        && !$past(we_i) |-> dat_o[7:2] == 6'h00)
        else $error("cmpa high bits not zero");
    chk_enable_clears: assert property (@(posedge clk_i)
        disable iff (rst_i) enable_rise |=> st.count == 10'h000)
        else $error("no clear");
    chk_pause_holds: assert property (@(posedge clk_i)
        disable iff (rst_i) paused && !enable_rise |=> $stable(st.count))
        else $error("count moved in pause");
    chk_clrsel_no_p: assert property (@(posedge clk_i)
        disable iff (rst_i) mode != MODE_PWM && st.ctrl_one[CLRSEL_BIT]
        |-> !set_p) else $error("period flag with clear select");
    chk_zero_a_flag: assert property (@(posedge clk_i)
        disable iff (rst_i) mode == MODE_COMPARE && st.cmpa == 10'h000
        |-> !set_a) else $error("a flag with zero compare");
    chk_pin_on_match: assert property (@(posedge clk_i)
        disable iff (rst_i) mode == MODE_COMPARE
        && $past(mode) == MODE_COMPARE && !set_a && !enable_rise
        && $stable(st.ctrl_one) |=> $stable(st.level))
        else $error("pin moved without match");
    chk_period_wrap: assert property (@(posedge clk_i)
        disable iff (rst_i) running && mode == MODE_PWM
        && st.per == 10'h000 && at_max |=> st.count == 10'h000)
        else $error("no 1024 wrap");
    chk_pwm_full: assert property (@(posedge clk_i)
        disable iff (rst_i) mode == MODE_PWM && st.cmpa >= st.per
        && st.per != 10'h000 |-> pwm_level) else $error("duty not full");
    chk_timer_free: assert property (@(posedge clk_i)
        disable iff (rst_i) mode == MODE_TIMER |=> pin_oe_n_o)
        else $error("pin driven");
    chk_flag_sticky: assert property (@(posedge clk_i)
        disable iff (rst_i) set_p |=> st.flag_p)
        else $error("period flag lost");
    chk_flag_a_sticky: assert property (@(posedge clk_i)
        disable iff (rst_i) set_a |=> st.flag_a)
        else $error("compare a flag lost");
    // ------------------------------------------------------------
    // checks: counter and pin
    // ------------------------------------------------------------
    chk_count_step: assert property (@(posedge clk_i)
        disable iff (rst_i) running && !clear_cnt
        |=> st.count == $past(st.count) + 10'h001)
        else $error("count did not step");
    chk_idle_holds: assert property (@(posedge clk_i)
        disable iff (rst_i) !enable |=> $stable(st.count))
        else $error("count moved while off");
    chk_enable_level: assert property (@(posedge clk_i)
        disable iff (rst_i) enable_rise
        |=> st.level == $past(st.ctrl_one[OCTRL_BIT]))
        else $error("initial level not loaded");
    chk_pwm_clear: assert property (@(posedge clk_i)
        disable iff (rst_i) running && mode == MODE_PWM && match_last
        |=> st.count == 10'h000) else $error("pwm period not cleared");
    chk_clrsel_clear: assert property (@(posedge clk_i)
        disable iff (rst_i) running && mode != MODE_PWM
        && st.ctrl_one[CLRSEL_BIT] && set_a |=> st.count == 10'h000)
        else $error("no clear on compare a");
    chk_period_clear: assert property (@(posedge clk_i)
        disable iff (rst_i) running && mode != MODE_PWM
        && !st.ctrl_one[CLRSEL_BIT] && set_p |=> st.count == 10'h000)
        else $error("no clear on period match");
    chk_zero_a_wrap: assert property (@(posedge clk_i)
        disable iff (rst_i) running && mode == MODE_COMPARE
        && st.cmpa == 10'h000 && at_max |=> st.count == 10'h000)
        else $error("no wrap at maximum");
    chk_match_toggle: assert property (@(posedge clk_i)
        disable iff (rst_i) set_a && mode == MODE_COMPARE
        && func == FUNC_TOGGLE |=> st.level != $past(st.level))
        else $error("no toggle on match");
    chk_match_high: assert property (@(posedge clk_i)
        disable iff (rst_i) set_a && mode == MODE_COMPARE
        && func == FUNC_HIGH |=> st.level)
        else $error("not high on match");
    chk_match_low: assert property (@(posedge clk_i)
        disable iff (rst_i) set_a && mode == MODE_COMPARE
        && func == FUNC_LOW |=> !st.level)
        else $error("not low on match");
    chk_forced_inactive: assert property (@(posedge clk_i)
        disable iff (rst_i) mode == MODE_PWM && func == FUNC_INACTIVE
        |=> pin_o == ($past(st.ctrl_one[OCTRL_BIT])
        ~^ $past(st.ctrl_one[POL_BIT]))) else $error("not inactive");
    chk_forced_active: assert property (@(posedge clk_i)
        disable iff (rst_i) mode == MODE_PWM && func == FUNC_ACTIVE
        |=> pin_o == ($past(st.ctrl_one[OCTRL_BIT])
        ^ $past(st.ctrl_one[POL_BIT]))) else $error("not active");
    chk_forced_counts: assert property (@(posedge clk_i)
        disable iff (rst_i) running && mode == MODE_PWM
        && func != FUNC_WAVE && !clear_cnt
        |=> st.count != $past(st.count)) else $error("forced pwm stopped");
    chk_wave_full: assert property (@(posedge clk_i)
        disable iff (rst_i) mode == MODE_PWM && func == FUNC_WAVE
        && st.cmpa >= st.per && st.per != 10'h000
        |=> pin_o == ($past(st.ctrl_one[OCTRL_BIT])
        ^ $past(st.ctrl_one[POL_BIT]))) else $error("full duty not active");
    chk_compare_drives: assert property (@(posedge clk_i)
        disable iff (rst_i) mode == MODE_COMPARE |=> !pin_oe_n_o)
        else $error("compare pin not driven");
endmodule

// >>> include/ptm_pkg.sv
// ptm_pkg: register map, field positions, modes and reset values of the
// periodic timer.
// assumes byte-wide registers, one per aligned 32-bit wishbone word.
package ptm_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ZERO_ADDR = 8'h00;
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h04;
    localparam logic [7:0] COUNT_LOW_ADDR = 8'h08;
    localparam logic [7:0] COUNT_HIGH_ADDR = 8'h0c;
    localparam logic [7:0] CMPA_LOW_ADDR = 8'h10;
    localparam logic [7:0] CMPA_HIGH_ADDR = 8'h14;
    localparam logic [7:0] PER_LOW_ADDR = 8'h18;
    localparam logic [7:0] PER_HIGH_ADDR = 8'h1c;
    localparam logic [7:0] FLAGS_ADDR = 8'h20;
    localparam logic [7:0] PRESCALE_ADDR = 8'h24;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PAUSE_BIT = 7;
    localparam int ENABLE_BIT = 3;
    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int FUNC_HI_BIT = 5;
    localparam int FUNC_LO_BIT = 4;
    localparam int OCTRL_BIT = 3;
    localparam int POL_BIT = 2;
    localparam int CLRSEL_BIT = 0;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    // ------------------------------------------------------------
    // reset values and constants
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ZERO_RESET = 8'h00;
    localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
    localparam logic [9:0] CMP_RESET = 10'h000;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam logic [9:0] COUNT_MAX = 10'h3ff;
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;
    localparam logic [1:0] FUNC_NONE = 2'h0;
    localparam logic [1:0] FUNC_LOW = 2'h1;
    localparam logic [1:0] FUNC_HIGH = 2'h2;
    localparam logic [1:0] FUNC_TOGGLE = 2'h3;
    localparam logic [1:0] FUNC_INACTIVE = 2'h0;
    localparam logic [1:0] FUNC_ACTIVE = 2'h1;
    localparam logic [1:0] FUNC_WAVE = 2'h2;
endpackage

// >>> core/tick_divider.sv
// tick_divider: one-cycle timer clock enable every (divisor+1) cycles.
// assumes divisor is stable software state.
`timescale 1ns/10ps
module tick_divider
    import ptm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] divisor_i,
    output logic tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } div_s;
    div_s st;
    div_s next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt >= divisor_i) begin
            next_st.cnt = 8'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;
endmodule

// >>> core/wb_byte_slave.sv
// wb_byte_slave: classic wishbone handshake, one wait state, ack pulse.
// assumes a master that holds its request until ack.
`timescale 1ns/10ps
module wb_byte_slave
    import ptm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic sel_i,
    output logic wr_o,
    output logic rd_o,
    output logic ack_o
);
    typedef struct packed {
        logic ack;
    } slv_s;
    slv_s st;
    slv_s next_st;

    always_comb begin
        next_st.ack = cyc_i & stb_i & ~st.ack;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // strobes fire in the cycle that ack is set, once per access
    assign wr_o = next_st.ack & we_i & sel_i;
    assign rd_o = next_st.ack & ~we_i;
    assign ack_o = st.ack;
endmodule

// >>> testbench/tb_top.sv
// tb_top: self-checking bench for the periodic timer through wishbone.
// assumes ptm_pkg and the core files are compiled before this file.
`timescale 1ns/10ps
module tb_top
    import ptm_pkg::*;
;
    // ------------------------------------------------------------
    // signals, clock and design
    // ------------------------------------------------------------
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] q;} reg_row_s;
    typedef struct packed {
        logic [7:0] c1; logic [9:0] per; logic [9:0] cmpa;
        logic [10:0] hi; logic [10:0] tot;
    } wave_row_s;
    typedef struct packed {
        logic [7:0] c1; logic [9:0] per; logic [9:0] cmpa;
        logic pin; logic oe_n; logic [1:0] flg; logic [1:0] msk;
    } level_row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic pin_o;
    logic pin_oe_n_o;
    logic [31:0] rd;
    logic [31:0] c;
    int n_fail = 0;
    int checks = 0;
    int hi;
    int tot;
    reg_row_s regs [9] = '{'{CMPA_LOW_ADDR, 8'ha5, 8'ha5},
        '{CMPA_HIGH_ADDR, 8'hff, 8'h03}, '{PER_LOW_ADDR, 8'h5a, 8'h5a},
        '{PER_HIGH_ADDR, 8'hfe, 8'h02}, '{CTRL_ZERO_ADDR, 8'h07, 8'h00},
        '{CTRL_ONE_ADDR, 8'h5a, 8'h5a}, '{8'h30, 8'hff, 8'h00},
        '{PRESCALE_ADDR, 8'h3c, 8'h3c}, '{PRESCALE_ADDR, 8'h00, 8'h00}};
    // pwm rows, then compare-mode toggle rows (period is value + 1)
    wave_row_s waves [8] = '{'{8'ha8, 10'd10, 10'd3, 11'd3, 11'd10},
        '{8'hac, 10'd10, 10'd3, 11'd7, 11'd10},
        '{8'ha0, 10'd10, 10'd3, 11'd7, 11'd10},
        '{8'ha4, 10'd10, 10'd3, 11'd3, 11'd10},
        '{8'ha8, 10'd0, 10'd100, 11'd100, 11'd1024},
        '{8'ha8, 10'd1023, 10'd1000, 11'd1000, 11'd1023},
        '{8'h30, 10'd20, 10'd5, 11'd21, 11'd42},
        '{8'h31, 10'd20, 10'd7, 11'd8, 11'd16}};
    level_row_s levels [8] = '{
        '{8'h20, 10'd20, 10'd5, 1'b1, 1'b0, 2'h3, 2'h3},
        '{8'h18, 10'd20, 10'd5, 1'b0, 1'b0, 2'h3, 2'h3},
        '{8'h08, 10'd20, 10'd5, 1'b1, 1'b0, 2'h3, 2'h3},
        '{8'h19, 10'd3, 10'd7, 1'b0, 1'b0, 2'h1, 2'h3},
        '{8'h19, 10'd20, 10'd0, 1'b1, 1'b0, 2'h0, 2'h3},
        '{8'h88, 10'd10, 10'd3, 1'b0, 1'b0, 2'h3, 2'h3},
        '{8'h98, 10'd10, 10'd3, 1'b1, 1'b0, 2'h3, 2'h3},
        '{8'ha8, 10'd10, 10'd10, 1'b1, 1'b0, 2'h2, 2'h2}};
    always #20 clk_i = ~clk_i;
    periodic_timer_compare_pwm dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one classic cycle; held until ack is sampled high
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) begin
            n_fail++;
            finish_test();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic setup(input logic [7:0] c1, input logic [9:0] per,
                         input logic [9:0] cmpa);
        wb(CTRL_ZERO_ADDR, 1'b1, 8'h00);
        wb(CTRL_ONE_ADDR, 1'b1, c1);
        wb(PER_LOW_ADDR, 1'b1, per[7:0]);
        wb(PER_HIGH_ADDR, 1'b1, {6'h00, per[9:8]});
        wb(CMPA_LOW_ADDR, 1'b1, cmpa[7:0]);
        wb(CMPA_HIGH_ADDR, 1'b1, {6'h00, cmpa[9:8]});
        wb(FLAGS_ADDR, 1'b1, 8'h03);
        wb(CTRL_ZERO_ADDR, 1'b1, 8'h08);
    endtask
    // high cycles and length of one pin period, rising edge to rising edge
    task automatic measure(output int h, output int t);
        int n;
        logic prev;
        h = 0;
        t = 0;
        n = 0;
        prev = pin_o;
        @(posedge clk_i);
        while (!(pin_o === 1'b1 && prev === 1'b0) && n < 3000) begin
            prev = pin_o;
            @(posedge clk_i);
            n++;
        end
        do begin
            t++;
            h += (pin_o === 1'b1) ? 1 : 0;
            prev = pin_o;
            @(posedge clk_i);
        end while (!(pin_o === 1'b1 && prev === 1'b0) && t < 3000);
        if (n >= 3000 || t >= 3000) begin
            n_fail++;
            finish_test();
        end
    endtask
    task automatic reset_check();
        for (int i = 0; i < 6; i++) begin
            wb(regs[i].a, 1'b0, 8'h00);
            chk("reset value", 32'h0, rd);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_check();
        foreach (regs[i]) begin
            wb(regs[i].a, 1'b1, regs[i].d);
            wb(regs[i].a, 1'b0, 8'h00);
            chk("readback", {24'h0, regs[i].q}, rd);
        end
        foreach (waves[i]) begin
            setup(waves[i].c1, waves[i].per, waves[i].cmpa);
            measure(hi, tot);
            chk("high cycles", {21'h0, waves[i].hi}, 32'(hi));
            chk("period", {21'h0, waves[i].tot}, 32'(tot));
        end
        foreach (levels[i]) begin
            setup(levels[i].c1, levels[i].per, levels[i].cmpa);
            chk("oe_n", 32'(levels[i].oe_n), 32'(pin_oe_n_o));
            repeat (1100) @(posedge clk_i);
            chk("pin", 32'(levels[i].pin), 32'(pin_o));
            wb(FLAGS_ADDR, 1'b0, 8'h00);
            chk("flags", 32'(levels[i].flg), rd & 32'(levels[i].msk));
        end
        setup(8'hc0, 10'd0, 10'd0);
        chk("timer oe_n", 32'h1, 32'(pin_oe_n_o));
        repeat (30) @(posedge clk_i);
        wb(CTRL_ZERO_ADDR, 1'b1, 8'h88);
        wb(COUNT_LOW_ADDR, 1'b0, 8'h00);
        c = rd;
        chk("count moved", 32'h1, 32'(c != 32'h0));
        repeat (20) @(posedge clk_i);
        wb(COUNT_LOW_ADDR, 1'b0, 8'h00);
        chk("held count", c, rd);
        wb(CTRL_ZERO_ADDR, 1'b1, 8'h00);
        wb(COUNT_LOW_ADDR, 1'b0, 8'h00);
        chk("kept count", c, rd);
        wb(CTRL_ZERO_ADDR, 1'b1, 8'h88);
        wb(COUNT_LOW_ADDR, 1'b0, 8'h00);
        chk("cleared count", 32'h0, rd);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        reset_check();
        finish_test();
    end
endmodule
